// ---- include/timer_regs.vh ----
// constants for the multichannel timer/event counter array
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

`define TMR_CHANNELS        11
`define TMR_WIDTH           16
`define TMR_PIN_CHANNELS    6
`define TMR_PRESCALE_BITS   5
`define TMR_PREDIV_BITS     4

// internal capture trigger sources
`define TMR_TRIG_SPLIT      5
`define TMR_TRIG_SRC_LOW    9
`define TMR_TRIG_SRC_HIGH   3

// operating modes
`define TMR_MODE_INTERVAL   2'h0
`define TMR_MODE_EVENT      2'h1
`define TMR_MODE_SQUARE     2'h2
`define TMR_MODE_TWO_PHASE  2'h3

// count source select
`define TMR_SRC_EXT         2'h0
`define TMR_SRC_T1          2'h1
`define TMR_SRC_T4          2'h2
`define TMR_SRC_T16         2'h3

// capture control
`define TMR_CAP_OFF         2'h0
`define TMR_CAP_EXT_AB      2'h1
`define TMR_CAP_EXT_A_EDGES 2'h2
`define TMR_CAP_INTERNAL    2'h3

// prescaler input divider select
`define TMR_PDIV_16         2'h0
`define TMR_PDIV_8          2'h1
`define TMR_PDIV_4          2'h2
`define TMR_PDIV_2          2'h3
`define TMR_PDIV_MASK_16    4'hf
`define TMR_PDIV_MASK_8     4'h7
`define TMR_PDIV_MASK_4     4'h3
`define TMR_PDIV_MASK_2     4'h1

// prescaler tap masks
`define TMR_T4_MASK         5'h03
`define TMR_T16_MASK        5'h0f

// reset values
`define TMR_COUNT_RESET     16'h0000
`define TMR_CMP_RESET       16'h0000
`define TMR_CAP_RESET       16'h0000

`endif

// ---- rtl/timer_event_array.v ----
// array of independent 16-bit timer/event counter channels
// Contract
// - eleven independent 16-bit timer/event counter channels
// - interval, event and square-wave modes per channel
// - quad-speed two-phase counting on last channel only
// - captures support frequency, width, time-difference measurement
// - up-counter with two compare-register comparators
// - compare1 double-buffered, compare0 written directly
// - two capture registers latch the counter
// - per-channel flip-flop, first six drive shared pins
// - only channels 0, 1 and the last channel have external inputs
// - capture trigger from channel 9, channels 5 and up from 3
// - per-channel run, control, mode, status, counter, compare, capture
// - 5-bit prescaler fed by peripheral clock /2../16
// - run bit starts; clearing it clears and stops
`include "timer_regs.vh"
`default_nettype none

module timer_event_array #(
    parameter N    = `TMR_CHANNELS,
    parameter W    = `TMR_WIDTH,
    parameter PINS = `TMR_PIN_CHANNELS
) (
    input  wire           clk,
    input  wire           rst_b,
    input  wire [1:0]     prescaler_clock_sel,
    input  wire [N-1:0]   prescaler_run_bit,
    input  wire [2*N-1:0] mode_sel,
    input  wire [2*N-1:0] source_sel,
    input  wire [2*N-1:0] capture_sel,
    input  wire [2*N-1:0] toggle_on_match,
    input  wire [N-1:0]   clear_on_match1,
    input  wire [N-1:0]   compare0_wr,
    input  wire [N-1:0]   compare1_wr,
    input  wire [W-1:0]   wr_data,
    input  wire           ch0_ext_input_a,
    input  wire           ch0_ext_input_b,
    input  wire           ch1_ext_input_a,
    input  wire           ch1_ext_input_b,
    input  wire           last_ext_input_a,
    input  wire           last_ext_input_b,
    input  wire [PINS-1:0] port_data,
    input  wire [PINS-1:0] port_func_sel,
    output wire [PINS-1:0] timer_pin_out,
    output wire [N-1:0]   flipflop_output,
    output wire [N*W-1:0] counter_value,
    output wire [N*W-1:0] compare0_value,
    output wire [N*W-1:0] compare1_value,
    output wire [N*W-1:0] capture0_value,
    output wire [N*W-1:0] capture1_value,
    output wire [N-1:0]   match0_flag,
    output wire [N-1:0]   match1_flag,
    output wire [N-1:0]   overflow_flag,
    output wire [N-1:0]   capture_flag
);

    function edge_rise;
        input prev;
        input cur;
        begin
            edge_rise = ~prev & cur;
        end
    endfunction

    function edge_fall;
        input prev;
        input cur;
        begin
            edge_fall = prev & ~cur;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // prescaler input divider: peripheral clock /2, /4, /8 or /16

    reg  [`TMR_PREDIV_BITS-1:0] prediv_q;
    reg  [`TMR_PREDIV_BITS-1:0] prediv_mask;
    wire                        base_tick;

    always @(posedge clk) begin
        if (!rst_b) begin
            prediv_q <= {`TMR_PREDIV_BITS{1'b0}};
        end else begin
            prediv_q <= prediv_q + 1'b1;
        end
    end

    always @* begin
        case (prescaler_clock_sel)
            `TMR_PDIV_16: prediv_mask = `TMR_PDIV_MASK_16;
            `TMR_PDIV_8:  prediv_mask = `TMR_PDIV_MASK_8;
            `TMR_PDIV_4:  prediv_mask = `TMR_PDIV_MASK_4;
            default:      prediv_mask = `TMR_PDIV_MASK_2;
        endcase
    end

    assign base_tick = ((prediv_q & prediv_mask) == prediv_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // external inputs: only channels 0, 1 and the last one have pins

    wire [N-1:0] raw_a;
    wire [N-1:0] raw_b;
    reg  [N-1:0] sync1_a_q;
    reg  [N-1:0] sync2_a_q;
    reg  [N-1:0] prev_a_q;
    reg  [N-1:0] sync1_b_q;
    reg  [N-1:0] sync2_b_q;
    reg  [N-1:0] prev_b_q;

    assign raw_a = {last_ext_input_a, {(N-3){1'b0}}, ch1_ext_input_a, ch0_ext_input_a};
    assign raw_b = {last_ext_input_b, {(N-3){1'b0}}, ch1_ext_input_b, ch0_ext_input_b};

    always @(posedge clk) begin
        if (!rst_b) begin
            sync1_a_q <= {N{1'b0}};
            sync2_a_q <= {N{1'b0}};
            prev_a_q  <= {N{1'b0}};
            sync1_b_q <= {N{1'b0}};
            sync2_b_q <= {N{1'b0}};
            prev_b_q  <= {N{1'b0}};
        end else begin
            sync1_a_q <= raw_a;
            sync2_a_q <= sync1_a_q;
            prev_a_q  <= sync2_a_q;
            sync1_b_q <= raw_b;
            sync2_b_q <= sync1_b_q;
            prev_b_q  <= sync2_b_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // channels

    wire [N-1:0] ff_all;

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : ch
            wire [1:0]   mode = mode_sel[2*i +: 2];
            wire [1:0]   src  = source_sel[2*i +: 2];
            wire [1:0]   csel = capture_sel[2*i +: 2];
            wire         run  = prescaler_run_bit[i];
            wire         t1;
            wire         t4;
            wire         t16;
            reg  [W-1:0] cnt_q;
            reg  [W-1:0] cmp0_q;
            reg  [W-1:0] cmp1_stage_q;
            reg  [W-1:0] cmp1_q;
            reg  [W-1:0] cap0_q;
            reg  [W-1:0] cap1_q;
            reg          ff_q;
            reg          trig_prev_q;
            reg          m0_q;
            reg          m1_q;
            reg          ovf_q;
            reg          capf_q;
            reg          tick_src;

            timer_prescaler #(
                .W (`TMR_PRESCALE_BITS)
            ) u_prescaler (
                .clk       (clk),
                .rst_b     (rst_b),
                .base_tick (base_tick),
                .run       (run),
                .tick1     (t1),
                .tick4     (t4),
                .tick16    (t16)
            );

            wire rise_a = edge_rise(prev_a_q[i], sync2_a_q[i]);
            wire fall_a = edge_fall(prev_a_q[i], sync2_a_q[i]);
            wire rise_b = edge_rise(prev_b_q[i], sync2_b_q[i]);
            wire trig   = (i < `TMR_TRIG_SPLIT) ? ff_all[`TMR_TRIG_SRC_LOW]
                                                : ff_all[`TMR_TRIG_SRC_HIGH];
            wire rise_t = edge_rise(trig_prev_q, trig);
            wire fall_t = edge_fall(trig_prev_q, trig);

            always @* begin
                case (src)
                    `TMR_SRC_T1:  tick_src = t1;
                    `TMR_SRC_T4:  tick_src = t4;
                    `TMR_SRC_T16: tick_src = t16;
                    default:      tick_src = rise_a;
                endcase
            end

            // quadrature: one input changes at a time, direction from phase order
            wire qd_mode = (i == N-1) && (mode == `TMR_MODE_TWO_PHASE);
            wire qd_step = run & qd_mode &
                           ((prev_a_q[i] ^ sync2_a_q[i]) ^ (prev_b_q[i] ^ sync2_b_q[i]));
            wire qd_up   = (prev_a_q[i] == sync2_b_q[i]);

            // two-phase code counts nothing outside the quadrature channel
            wire         adv    = run & (mode != `TMR_MODE_TWO_PHASE) &
                                  ((mode == `TMR_MODE_EVENT) ? rise_a : tick_src);
            wire [W-1:0] up_val = cnt_q + 1'b1;
            wire [W-1:0] dn_val = cnt_q - 1'b1;
            wire         m0     = adv & (up_val == cmp0_q);
            wire         m1     = adv & (up_val == cmp1_q);
            wire         ovf    = adv & (cnt_q == {W{1'b1}});
            wire         clr    = m1 & (clear_on_match1[i] | (mode == `TMR_MODE_SQUARE));
            wire         sq     = (mode == `TMR_MODE_SQUARE);
            wire         tg     = (m0 & (toggle_on_match[2*i] | sq)) ^
                                  (m1 & (toggle_on_match[2*i+1] | sq));
            wire         cap0   = ((csel == `TMR_CAP_EXT_AB) | (csel == `TMR_CAP_EXT_A_EDGES))
                                  ? rise_a : ((csel == `TMR_CAP_INTERNAL) & rise_t);
            wire         cap1   = (csel == `TMR_CAP_EXT_AB) ? rise_b :
                                  (csel == `TMR_CAP_EXT_A_EDGES) ? fall_a :
                                  ((csel == `TMR_CAP_INTERNAL) & fall_t);

            always @(posedge clk) begin
                if (!rst_b) begin
                    cnt_q        <= `TMR_COUNT_RESET;
                    cmp0_q       <= `TMR_CMP_RESET;
                    cmp1_stage_q <= `TMR_CMP_RESET;
                    cmp1_q       <= `TMR_CMP_RESET;
                    cap0_q       <= `TMR_CAP_RESET;
                    cap1_q       <= `TMR_CAP_RESET;
                    ff_q         <= 1'b0;
                    trig_prev_q  <= 1'b0;
                    m0_q         <= 1'b0;
                    m1_q         <= 1'b0;
                    ovf_q        <= 1'b0;
                    capf_q       <= 1'b0;
                end else begin
                    trig_prev_q <= trig;
                    m0_q        <= m0;
                    m1_q        <= m1;
                    ovf_q       <= ovf;
                    capf_q      <= cap0 | cap1;
                    if (compare0_wr[i]) begin
                        cmp0_q <= wr_data;
                    end
                    if (compare1_wr[i]) begin
                        cmp1_stage_q <= wr_data;
                    end
                    // staged value goes live when stopped or at the end of a period
                    if (!run | clr | ovf) begin
                        cmp1_q <= cmp1_stage_q;
                    end
                    if (!run) begin
                        cnt_q <= `TMR_COUNT_RESET;
                    end else if (qd_step) begin
                        cnt_q <= qd_up ? up_val : dn_val;
                    end else if (adv) begin
                        cnt_q <= clr ? `TMR_COUNT_RESET : up_val;
                    end
                    if (tg) begin
                        ff_q <= ~ff_q;
                    end
                    if (cap0) begin
                        cap0_q <= cnt_q;
                    end
                    if (cap1) begin
                        cap1_q <= cnt_q;
                    end
                end
            end

            if (i < PINS) begin : pin
                reg pin_q;
                always @(posedge clk) begin
                    if (!rst_b) begin
                        pin_q <= 1'b0;
                    end else begin
                        pin_q <= port_func_sel[i] ? ff_q : port_data[i];
                    end
                end
                assign timer_pin_out[i] = pin_q;
            end

            assign ff_all[i]               = ff_q;
            assign counter_value[W*i +: W]  = cnt_q;
            assign compare0_value[W*i +: W] = cmp0_q;
            assign compare1_value[W*i +: W] = cmp1_q;
            assign capture0_value[W*i +: W] = cap0_q;
            assign capture1_value[W*i +: W] = cap1_q;
            assign match0_flag[i]          = m0_q;
            assign match1_flag[i]          = m1_q;
            assign overflow_flag[i]        = ovf_q;
            assign capture_flag[i]         = capf_q;
        end
    endgenerate

    assign flipflop_output = ff_all;

endmodule // timer_event_array

`default_nettype wire

// ---- rtl/timer_prescaler.v ----
// per-channel 5-bit prescaler producing the t1, t4 and t16 count enables
`include "timer_regs.vh"
`default_nettype none

module timer_prescaler #(
    parameter W = `TMR_PRESCALE_BITS
) (
    input  wire clk,
    input  wire rst_b,
    input  wire base_tick,
    input  wire run,
    output wire tick1,
    output wire tick4,
    output wire tick16
);

    reg [W-1:0] cnt_q;

    // stopping clears the prescaler
    always @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= {W{1'b0}};
        end else if (!run) begin
            cnt_q <= {W{1'b0}};
        end else if (base_tick) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign tick1  = run & base_tick;
    assign tick4  = tick1 & ((cnt_q & `TMR_T4_MASK) == `TMR_T4_MASK);
    assign tick16 = tick1 & ((cnt_q & `TMR_T16_MASK) == `TMR_T16_MASK);

endmodule // timer_prescaler

`default_nettype wire

// ---- sim/event_source_model.sv ----
// far-side event sources: random edges on two pin channels, quadrature encoder on the last
`default_nettype none
module event_source_model (
    input  wire logic clk,
    input  wire logic en,
    output var  logic ch0_ext_input_a,
    output var  logic ch0_ext_input_b,
    output var  logic ch1_ext_input_a,
    output var  logic ch1_ext_input_b,
    output wire logic last_ext_input_a,
    output wire logic last_ext_input_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] q = 2'h0;
    // order 00,10,11,01 moves one line per step, always counting upward
    assign last_ext_input_a = q[1] ^ q[0];
    assign last_ext_input_b = q[1];
    initial {ch0_ext_input_a, ch0_ext_input_b, ch1_ext_input_a, ch1_ext_input_b} = 4'h0;
    always @(posedge clk) begin
        if (en) begin
            {ch0_ext_input_a, ch0_ext_input_b, ch1_ext_input_a, ch1_ext_input_b} <=
                {ch0_ext_input_a, ch0_ext_input_b, ch1_ext_input_a, ch1_ext_input_b}
                ^ 4'($urandom_range(15) & $urandom_range(15));
            q <= q + 2'($urandom_range(1));
        end
    end
endmodule // event_source_model
`default_nettype wire

// ---- sim/multichannel_timer_event_counter_tb.sv ----
// self-checking bench for the timer/event counter array
`include "timer_regs.vh"
`default_nettype none
module multichannel_timer_event_counter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N = `TMR_CHANNELS;
    localparam int W = `TMR_WIDTH;
    logic           clk = 1'b0, rst_b = 1'b0, src_en = 1'b0, pa = 1'b0, p3 = 1'b0, p9 = 1'b0;
    logic [1:0]     prescaler_clock_sel = `TMR_PDIV_2, pq = 2'h0;
    logic [N-1:0]   prescaler_run_bit = '0, clear_on_match1 = '0, compare0_wr = '0;
    logic [N-1:0]   compare1_wr = '0;
    logic [2*N-1:0] mode_sel = '0, capture_sel = '0, toggle_on_match = '0;
    logic [2*N-1:0] source_sel = {N{`TMR_SRC_T1}};
    logic [W-1:0]   wr_data = '0;
    logic           pb = 1'b0;
    logic [5:0]     port_data = '0, port_func_sel = '0;
    wire logic      ch0_ext_input_a, ch0_ext_input_b, ch1_ext_input_a, ch1_ext_input_b;
    wire logic      last_ext_input_a, last_ext_input_b;
    wire logic [5:0] timer_pin_out;
    wire logic [N-1:0] flipflop_output, match0_flag, match1_flag, overflow_flag, capture_flag;
    wire logic [N*W-1:0] counter_value, compare0_value, compare1_value, capture0_value;
    wire logic [N*W-1:0] capture1_value;
    int n_fail = 0, checks = 0, rises, steps, tog3, tog9, cf0, cf5, capb;
    timer_event_array u_dut (.clk, .rst_b, .prescaler_clock_sel, .prescaler_run_bit, .mode_sel,
        .source_sel, .capture_sel, .toggle_on_match, .clear_on_match1, .compare0_wr,
        .compare1_wr, .wr_data, .ch0_ext_input_a, .ch0_ext_input_b, .ch1_ext_input_a,
        .ch1_ext_input_b, .last_ext_input_a, .last_ext_input_b, .port_data, .port_func_sel,
        .timer_pin_out, .flipflop_output, .counter_value, .compare0_value, .compare1_value,
        .capture0_value, .capture1_value, .match0_flag, .match1_flag, .overflow_flag,
        .capture_flag);
    event_source_model u_src (.clk, .en(src_en), .ch0_ext_input_a, .ch0_ext_input_b,
        .ch1_ext_input_a, .ch1_ext_input_b, .last_ext_input_a, .last_ext_input_b);
    initial forever #50 clk = ~clk;
    // reference counts of events seen at the pins and flip-flops
    always @(posedge clk) begin
        pa <= ch0_ext_input_a;
        pq <= {last_ext_input_a, last_ext_input_b};
        p3 <= flipflop_output[3];
        p9 <= flipflop_output[9];
        pb <= ch0_ext_input_b;
        // a b rise captures the a rises seen before it
        if (ch0_ext_input_b & ~pb) capb <= rises;
        rises <= rises + int'(ch0_ext_input_a & ~pa);
        steps <= steps + int'(pq != {last_ext_input_a, last_ext_input_b});
        tog3 <= tog3 + int'(p3 != flipflop_output[3]);
        tog9 <= tog9 + int'(p9 != flipflop_output[9]);
        cf0 <= cf0 + int'(capture_flag[0]);
        cf5 <= cf5 + int'(capture_flag[5]);
    end
    function automatic logic [W-1:0] exp_cap(input int r);
        return W'(r - 1);
    endfunction
    task automatic summarize();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic clr();
        {rises, steps, tog3, tog9, cf0, cf5, capb} = '0;
    endtask
    task automatic wr(input int ch, input bit one, input logic [W-1:0] d);
        @(negedge clk);
        wr_data = d;
        if (one) compare1_wr[ch] = 1'b1;
        else compare0_wr[ch] = 1'b1;
        @(negedge clk);
        compare0_wr = '0;
        compare1_wr = '0;
    endtask
    task automatic wait_flag(input int ch);
        int t;
        for (t = 0; t < 300 && match0_flag[ch] !== 1'b1; t++) @(negedge clk);
        if (t == 300) begin
            n_fail++;
            summarize();
        end
    endtask
    task automatic wait_ff(input int ch, output int n);
        logic f;
        f = flipflop_output[ch];
        for (n = 0; n < 300 && flipflop_output[ch] === f; n++) @(negedge clk);
        if (n == 300) begin
            n_fail++;
            summarize();
        end
    endtask
    initial begin
        int ch;
        int t;
        logic [W-1:0] k;
        void'($urandom(27));
        clr();
        cyc(8);
        rst_b = 1'b1;
        cyc(1);
        chk(counter_value[W-1:0], '0);
        for (int i = 0; i < 6; i++) begin
            ch = (i == 0) ? 0 : int'($urandom_range(N - 1));
            k = (i == 0) ? 16'h0001 : W'($urandom_range(40, 2));
            wr(ch, 1'b0, k);
            prescaler_run_bit[ch] = 1'b1;
            wait_flag(ch);
            chk(counter_value[ch*W +: W], k);
            chk(compare0_value[ch*W +: W], k);
            chk(counter_value[((ch + 1) % N)*W +: W], '0);
            prescaler_run_bit[ch] = 1'b0;
            cyc(2);
            chk(counter_value[ch*W +: W], '0);
        end
        prescaler_run_bit[0] = 1'b1;
        wr(0, 1'b1, 16'h1234);
        chk(compare1_value[W-1:0], '0);
        prescaler_run_bit[0] = 1'b0;
        cyc(2);
        chk(compare1_value[W-1:0], 16'h1234);
        port_data = 6'($urandom);
        cyc(2);
        chk(timer_pin_out, port_data);
        mode_sel = {`TMR_MODE_TWO_PHASE, 14'h0, `TMR_MODE_EVENT, `TMR_MODE_TWO_PHASE,
            `TMR_MODE_EVENT};
        source_sel[1:0] = `TMR_SRC_EXT;
        source_sel[5:4] = `TMR_SRC_EXT;
        capture_sel[1:0] = `TMR_CAP_EXT_AB;
        prescaler_run_bit = 11'h407;
        cyc(4);
        clr();
        src_en = 1'b1;
        cyc(200);
        src_en = 1'b0;
        cyc(8);
        chk(counter_value[W-1:0], W'(rises));
        chk(capture0_value[W-1:0], exp_cap(rises));
        chk(capture1_value[W-1:0], W'(capb));
        chk(counter_value[2*W +: W], '0);
        chk(counter_value[W +: W], '0);
        chk(counter_value[10*W +: W], W'(steps));
        mode_sel = '0;
        mode_sel[7:6] = `TMR_MODE_SQUARE;
        mode_sel[19:18] = `TMR_MODE_SQUARE;
        source_sel = {N{`TMR_SRC_T1}};
        capture_sel = '0;
        capture_sel[1:0] = `TMR_CAP_INTERNAL;
        capture_sel[11:10] = `TMR_CAP_INTERNAL;
        port_func_sel = 6'h08;
        prescaler_run_bit = 11'h208;
        wr(3, 1'b1, 16'h0006);
        wr(9, 1'b1, 16'h0004);
        prescaler_run_bit = '0;
        wr(3, 1'b0, 16'h0003);
        wr(9, 1'b0, 16'h0002);
        cyc(2);
        clr();
        prescaler_run_bit = 11'h229;
        cyc(150);
        prescaler_run_bit = 11'h021;
        cyc(8);
        chk(W'(cf0), W'(tog9));
        chk(W'(cf5), W'(tog3));
        chk(tog9 > 8, 1'b1);
        chk(timer_pin_out[3], flipflop_output[3]);
        // /4 base, t4 source, clear and toggle on compare1 = 3: 48 clocks per toggle
        prescaler_clock_sel = `TMR_PDIV_4;
        source_sel[9:8] = `TMR_SRC_T4;
        clear_on_match1[4] = 1'b1;
        toggle_on_match[9] = 1'b1;
        wr(4, 1'b1, 16'h0003);
        cyc(1);
        prescaler_run_bit[4] = 1'b1;
        wait_ff(4, t);
        wait_ff(4, t);
        chk(W'(t), 16'h0030);
        summarize();
    end
endmodule // multichannel_timer_event_counter_tb
bind timer_event_array timer_event_array_props #(.N(N), .W(W), .PINS(PINS)) u_props (.clk,
    .rst_b, .prescaler_run_bit, .mode_sel, .source_sel, .compare0_wr, .wr_data,
    .flipflop_output, .counter_value, .compare0_value, .compare1_value, .capture0_value,
    .match0_flag, .match1_flag, .overflow_flag, .capture_flag);
`default_nettype wire

// ---- sim/timer_event_array_props.sv ----
// concurrent checks on the timer/event counter array ports
`include "timer_regs.vh"
`default_nettype none
module timer_event_array_props #(
    parameter N    = 11,
    parameter W    = 16,
    parameter PINS = 6
) (
    input wire logic           clk,
    input wire logic           rst_b,
    input wire logic [N-1:0]   prescaler_run_bit,
    input wire logic [2*N-1:0] mode_sel,
    input wire logic [2*N-1:0] source_sel,
    input wire logic [N-1:0]   compare0_wr,
    input wire logic [W-1:0]   wr_data,
    input wire logic [N-1:0]   flipflop_output,
    input wire logic [N*W-1:0] counter_value,
    input wire logic [N*W-1:0] compare0_value,
    input wire logic [N*W-1:0] compare1_value,
    input wire logic [N*W-1:0] capture0_value,
    input wire logic [N-1:0]   match0_flag,
    input wire logic [N-1:0]   match1_flag,
    input wire logic [N-1:0]   overflow_flag,
    input wire logic [N-1:0]   capture_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic [W-1:0] c0 = counter_value[W-1:0];
    wire logic [W-1:0] c2 = counter_value[3*W-1:2*W];
    wire logic [W-1:0] k0 = compare0_value[W-1:0];
    wire logic [W-1:0] k1 = compare1_value[W-1:0];
    wire logic         ev1 = match1_flag[0] | overflow_flag[0];
    wire logic         idle2 = mode_sel[5:4] == `TMR_MODE_EVENT
        || mode_sel[5:4] == `TMR_MODE_TWO_PHASE || source_sel[5:4] == `TMR_SRC_EXT;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_stop;
        !prescaler_run_bit[0];
    endsequence
    property p_reset_out;
        $rose(rst_b) |-> counter_value == '0 && flipflop_output == '0 && capture_flag == '0;
    endproperty
    property p_stop_clear;
        s_stop |=> c0 == '0;
    endproperty
    property p_step;
        $changed(c0) |-> c0 == $past(c0) + 16'h0001 || c0 == '0;
    endproperty
    property p_match0;
        match0_flag[0] && !match1_flag[0] && $stable(k0) |-> c0 == k0 || $past(c0) == k0;
    endproperty
    property p_wr0;
        compare0_wr[0] |=> k0 == $past(wr_data);
    endproperty
    property p_cmp1_buf;
        $changed(k1) |-> (!$past(prescaler_run_bit[0]) || !$past(prescaler_run_bit[0], 2)
            || ev1 || $past(ev1)) or ##1 ev1;
    endproperty
    property p_ff_match;
        $changed(flipflop_output[3]) && $past(prescaler_run_bit[3])
            |-> ##[0:1] (match0_flag[3] || match1_flag[3]);
    endproperty
    property p_nopin;
        idle2 |=> c2 == $past(c2) || c2 == '0;
    endproperty
    property p_cap;
        $changed(capture0_value[W-1:0]) |-> capture_flag[0];
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not clear after reset");
    a_stop_clear: assert property (p_stop_clear) else $error("counter not cleared on stop");
    a_step: assert property (p_step) else $error("counter moved by other than one");
    a_match0: assert property (p_match0) else $error("match0 without equality");
    a_wr0: assert property (p_wr0) else $error("compare0 not written directly");
    a_cmp1_buf: assert property (p_cmp1_buf) else $error("compare1 changed while running");
    a_ff_match: assert property (p_ff_match) else $error("flip-flop moved without match");
    a_nopin: assert property (p_nopin) else $error("pinless channel counted events");
    a_cap: assert property (p_cap) else $error("capture without flag");
endmodule // timer_event_array_props
`default_nettype wire
